// ===== rtl/serial_eeprom_cmd_master.sv
// three-wire serial eeprom command master: frames, read capture, ready polling
`timescale 1ns/1ns
// Function
// - chip select is active high: high selects the eeprom, low deselects it.
// - after chip select rises, wait at least 50 ns before the first shift clock edge.
// - with word width select high the eeprom holds 64 words of 16 bits and the address field is 6 bits.
// - each frame is sent as start bit 1, two-bit operation code, address, then data.
// - read is 10, write is 01 plus data msb first, and 00 with leading address 10/11/00 wipes/unlocks/locks.
// - a read returns a leading dummy 0 which the master discards.
// - after a write or wipe frame chip select goes low for at least 250 ns.
// - chip select then rises again and the data output is polled until high (ready).
// - the master changes its serial output only away from rising shift clock edges.
// - the eeprom updates its output on rising edges, so the master samples away from them.
// - all bits are shifted most significant first.
// - a byte-padded 25-bit write frame carries leading zeros with the start bit at the low end of byte one; the master sends it unpadded, start bit first.
module serial_eeprom_cmd_master #(
  parameter int unsigned HALF_CYC = ee_cmd_pkg::HALF_PERIOD_CYC
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic word_width_select_i,
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic [2:0] cmd_i,
  input wire logic [6:0] cmd_addr_i,
  input wire logic [15:0] cmd_wdata_i,
  output logic done_o,
  output logic [15:0] rdata_o,
  output logic chip_select_o,
  output logic shift_clock_o,
  output logic eeprom_serial_input_o,
  input wire logic eeprom_serial_output_i
);
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_SETUP = 6'h02,
    ST_SHIFT = 6'h04,
    ST_GAP = 6'h08,
    ST_POLL = 6'h10,
    ST_FINISH = 6'h20
  } state_t;

  state_t state;
  state_t next_state;
  logic [31:0] frame;
  logic [5:0] bits_left;
  logic [15:0] timer;
  logic [16:0] rx;
  logic is_read;
  logic is_prog;
  logic sync_do;
  logic rx_phase;

  ee_pin_sync u_sync (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .pin_i(eeprom_serial_output_i),
    .level_o(sync_do)
  );

  // frame built msb-aligned; unused tail bits are zero
  function automatic logic [31:0] build_frame(input logic [2:0] cmd, input logic [6:0] addr,
                                             input logic [15:0] wd, input logic wide);
    logic [1:0] op;
    logic [6:0] fld;
    logic [31:0] f;
    op = ee_cmd_pkg::OP_SPECIAL;
    fld = addr;
    f = '0;
    unique case (cmd)
      ee_cmd_pkg::CMD_READ: op = ee_cmd_pkg::OP_READ;
      ee_cmd_pkg::CMD_WRITE: op = ee_cmd_pkg::OP_WRITE;
      ee_cmd_pkg::CMD_BULK_WIPE: fld = {ee_cmd_pkg::SUB_WIPE, 5'h00};
      ee_cmd_pkg::CMD_UNLOCK: fld = {ee_cmd_pkg::SUB_UNLOCK, 5'h00};
      default: fld = {ee_cmd_pkg::SUB_LOCK, 5'h00};
    endcase
    if (wide)
      f = {ee_cmd_pkg::START_BIT, op, (cmd > ee_cmd_pkg::CMD_WRITE) ? fld[6:1] : addr[5:0], wd, 7'h00};
    else
      f = {ee_cmd_pkg::START_BIT, op, fld, wd[7:0], 14'h0000};
    return f;
  endfunction : build_frame

  function automatic logic [5:0] frame_len(input logic [2:0] cmd, input logic wide);
    logic [5:0] n;
    n = wide ? 6'h09 : 6'h0a;
    if (cmd == ee_cmd_pkg::CMD_WRITE)
      n = wide ? 6'h19 : 6'h12;
    else if (cmd == ee_cmd_pkg::CMD_READ)
      n = n + (wide ? 6'h11 : 6'h09); // dummy rides the last address clock; one extra rise samples the last bit
    return n;
  endfunction : frame_len

  wire cmd_take = (state == ST_IDLE) && cmd_valid_i;
  wire half_tick = (timer == 16'h0000);
  wire rx_word_wide = word_width_select_i;
  wire [15:0] rx_word = rx_word_wide ? rx[15:0] : {8'h00, rx[7:0]};
  assign cmd_ready_o = (state == ST_IDLE);

  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_IDLE: if (cmd_valid_i) next_state = ST_SETUP;
      ST_SETUP: if (half_tick) next_state = ST_SHIFT;
      ST_SHIFT:
        if (half_tick && rx_phase && bits_left == 6'h01)
          next_state = is_prog ? ST_GAP : ST_FINISH;
      ST_GAP: if (half_tick) next_state = ST_POLL;
      ST_POLL: if (half_tick) next_state = sync_do ? ST_FINISH : ST_GAP;
      ST_FINISH: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  // timer counts down one phase; each state loads its own length
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      timer <= 16'h0000;
    else if (cmd_take)
      timer <= 16'(ee_cmd_pkg::SELECT_SETUP_CYC - 1);
    else if (state == ST_SHIFT && half_tick && rx_phase && bits_left == 6'h01 && is_prog)
      timer <= 16'(ee_cmd_pkg::DESELECT_HOLD_CYC); // select drops one cycle after this edge
    else if (state == ST_GAP && half_tick)
      // the ready level must clear the pin synchroniser even with a short half period
      timer <= 16'(HALF_CYC + ee_cmd_pkg::DESELECT_HOLD_CYC - 1);
    else if (state == ST_POLL && half_tick)
      timer <= 16'(ee_cmd_pkg::DESELECT_HOLD_CYC - 1);
    else if (half_tick)
      timer <= 16'(HALF_CYC - 1);
    else
      timer <= timer - 16'h0001;
  end

  // rx_phase 0: clock low, data changed; 1: clock high after rising edge
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      frame <= 32'h00000000;
      bits_left <= 6'h00;
      rx <= 17'h00000;
      rx_phase <= 1'h0;
      is_read <= 1'h0;
      is_prog <= 1'h0;
      shift_clock_o <= 1'h0;
      eeprom_serial_input_o <= 1'h0;
    end
    else if (cmd_take)
    begin
      frame <= build_frame(cmd_i, cmd_addr_i, cmd_wdata_i, word_width_select_i);
      bits_left <= frame_len(cmd_i, word_width_select_i);
      is_read <= (cmd_i == ee_cmd_pkg::CMD_READ);
      is_prog <= (cmd_i == ee_cmd_pkg::CMD_WRITE) || (cmd_i == ee_cmd_pkg::CMD_BULK_WIPE);
      rx <= 17'h00000;
      rx_phase <= 1'h0;
      shift_clock_o <= 1'h0;
    end
    else if (state == ST_SETUP && half_tick)
    begin
      eeprom_serial_input_o <= frame[31];
      frame <= {frame[30:0], 1'h0};
    end
    else if (state == ST_SHIFT && half_tick)
    begin
      rx_phase <= ~rx_phase;
      if (!rx_phase)
      begin
        // the bit put out at the previous rise has cleared the synchroniser by now when the half period is three cycles or more
        rx <= {rx[15:0], sync_do};
        shift_clock_o <= 1'h1;
      end
      else
      begin
        // falling edge: present the next bit
        shift_clock_o <= 1'h0;
        eeprom_serial_input_o <= frame[31];
        frame <= {frame[30:0], 1'h0};
        bits_left <= bits_left - 6'h01;
      end
    end
    else if (state == ST_FINISH)
      eeprom_serial_input_o <= 1'h0;
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      chip_select_o <= 1'h0;
    else
      // select outlives the last falling clock edge by one cycle so the two never move together
      chip_select_o <= (next_state == ST_SETUP) || (next_state == ST_SHIFT) || (next_state == ST_POLL) ||
                       (state == ST_SHIFT);
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      done_o <= 1'h0;
      rdata_o <= 16'h0000;
    end
    else
    begin
      done_o <= (state == ST_FINISH);
      if (state == ST_FINISH && is_read)
        rdata_o <= rx_word;
    end
  end
endmodule : serial_eeprom_cmd_master

// ===== rtl/ee_cmd_pkg.sv
// constants shared by the serial eeprom command master
package ee_cmd_pkg;
  localparam int unsigned CLK_MHZ = 100;
  // timing figures in ns, converted to cycles with a round up for least times
  localparam int unsigned SELECT_SETUP_NS = 50;
  localparam int unsigned DESELECT_HOLD_NS = 250;
  localparam int unsigned SELECT_SETUP_CYC = (SELECT_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned DESELECT_HOLD_CYC = (DESELECT_HOLD_NS * CLK_MHZ + 999) / 1000;
  // half period of the shift clock in system cycles (500 kbit/s at 100 MHz)
  localparam int unsigned HALF_PERIOD_CYC = 100;
  localparam int unsigned ADDR_W_WIDE = 6;
  localparam int unsigned ADDR_W_NARROW = 7;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned FRAME_MAX = 32;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_SPECIAL = 2'h0;
  localparam logic [1:0] SUB_WIPE = 2'h2;
  localparam logic [1:0] SUB_UNLOCK = 2'h3;
  localparam logic [1:0] SUB_LOCK = 2'h0;
  localparam logic START_BIT = 1'h1;
  // user command codes
  localparam logic [2:0] CMD_READ = 3'h0;
  localparam logic [2:0] CMD_WRITE = 3'h1;
  localparam logic [2:0] CMD_BULK_WIPE = 3'h2;
  localparam logic [2:0] CMD_UNLOCK = 3'h3;
  localparam logic [2:0] CMD_LOCK = 3'h4;
endpackage : ee_cmd_pkg

// ===== rtl/ee_pin_sync.sv
// three-stage synchroniser for the eeprom data output pin
`timescale 1ns/1ns
module ee_pin_sync (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic pin_i,
  output logic level_o
);
  logic s1;
  logic s2;
  logic s3;
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      s1 <= 1'h0;
      s2 <= 1'h0;
      s3 <= 1'h0;
      level_o <= 1'h0;
    end
    else
    begin
      s1 <= pin_i;
      s2 <= s1;
      s3 <= s2;
      // a change counts only once stages two and three agree
      if (s2 == s3)
        level_o <= s3;
    end
  end
endmodule : ee_pin_sync

// ===== verif/serial_eeprom_cmd_master_asserts.sv
// concurrent checks on the eeprom command master pins
`timescale 1ns/1ns
module serial_eeprom_cmd_master_asserts (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic cmd_valid_i,
  input wire logic cmd_ready_o,
  input wire logic [2:0] cmd_i,
  input wire logic chip_select_o,
  input wire logic shift_clock_o,
  input wire logic eeprom_serial_input_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  logic prog, first, polling;
  logic [7:0] low_cnt;
  always_ff @(posedge clk_i or posedge sys_rst_i)
    if (sys_rst_i)
    begin
      prog <= 1'b0;
      first <= 1'b0;
      polling <= 1'b0;
      low_cnt <= 8'h00;
    end
    else
    begin
      if (cmd_valid_i && cmd_ready_o)
        prog <= cmd_i == ee_cmd_pkg::CMD_WRITE || cmd_i == ee_cmd_pkg::CMD_BULK_WIPE;
      // only the select rises after a write or wipe frame are ready polls
      polling <= !(cmd_valid_i && cmd_ready_o) && (polling || ($fell(chip_select_o) && prog));
      first <= $rose(chip_select_o) || (first && !shift_clock_o);
      low_cnt <= chip_select_o ? 8'h00 : low_cnt + {7'h00, low_cnt != 8'hff};
    end
  sequence sel_rise;
    $rose(chip_select_o);
  endsequence
  setup_gap_a: assert property (sel_rise |-> (!shift_clock_o)[*5])
    else $error("shift clock too soon after select");
  deselect_min_a: assert property (sel_rise ##0 polling |-> low_cnt >= ee_cmd_pkg::DESELECT_HOLD_CYC)
    else $error("deselect gap too short");
  poll_quiet_a: assert property (sel_rise ##0 polling |-> (!shift_clock_o)[*8])
    else $error("shift clock during ready poll");
  din_stable_a: assert property ($rose(shift_clock_o) |-> $stable(eeprom_serial_input_o) ##1 $stable(eeprom_serial_input_o))
    else $error("serial data moved at rising edge");
  start_bit_a: assert property ($rose(shift_clock_o) && first |-> eeprom_serial_input_o)
    else $error("first bit of frame not one");
  sk_idle_a: assert property (!chip_select_o |-> !shift_clock_o)
    else $error("shift clock high while deselected");
  frame_hold_a: assert property ($fell(chip_select_o) |-> !$past(shift_clock_o))
    else $error("select dropped mid clock");
  idle_desel_a: assert property (cmd_ready_o |-> !chip_select_o)
    else $error("select high while idle");
endmodule : serial_eeprom_cmd_master_asserts

// ===== verif/ee_word_model.sv
// behavioural 1024-bit serial eeprom in either word organisation
`timescale 1ns/1ns
module ee_word_model #(
  parameter int BUSY_POLLS = 2
) (
  input wire logic select_i,
  input wire logic sclk_i,
  input wire logic din_i,
  input wire logic org_i,
  output logic dout_o
);
  // one store of 128 bytes; a 16-bit word is an even byte (high) and the odd byte after it
  logic [7:0] mem [128];
  logic [24:0] sr;
  logic [15:0] rd;
  logic st = 1'b0;
  logic [1:0] op = 2'h0;
  logic [1:0] sub = 2'h0;
  logic [6:0] ad = 7'h00;
  logic unlocked = 1'b0;
  logic rdy = 1'b1;
  logic dq = 1'b0;
  int n = 0;
  int busy = 0;
  int hlen;
  always_comb
    hlen = org_i ? 9 : 10;
  // deselected line shows the inverse of the last bit, never a stale copy
  assign dout_o = select_i ? dq : ~dq;
  always @(posedge select_i)
  begin
    n = 0;
    dq = busy == 0;
    rdy = dq;
    busy = busy > 0 ? busy - 1 : 0;
  end
  always @(posedge sclk_i)
    if (select_i)
    begin
      sr = {sr[23:0], din_i};
      n++;
      if (n == hlen)
      begin
        st = sr[hlen - 1];
        op = sr[hlen - 2 -: 2];
        sub = sr[hlen - 4 -: 2];
        ad = org_i ? {1'b0, sr[5:0]} : sr[6:0];
        rd = org_i ? {mem[{ad[5:0], 1'b0}], mem[{ad[5:0], 1'b1}]} : {mem[ad], 8'h00};
        // a frame sent while still busy reads nothing, so a skipped poll shows up in the data
        if (!rdy)
          rd = 16'h0000;
        dq = 1'b0;
      end
      else if (n > hlen && st && op == 2'h2)
      begin
        dq = rd[15];
        rd = {rd[14:0], 1'b0};
      end
    end
  always @(negedge select_i)
    if (st && op == 2'h1 && n == hlen + (org_i ? 16 : 8) && unlocked && rdy)
    begin
      if (org_i)
      begin
        mem[{ad[5:0], 1'b0}] = sr[15:8];
        mem[{ad[5:0], 1'b1}] = sr[7:0];
      end
      else
        mem[ad] = sr[7:0];
      busy = BUSY_POLLS;
    end
    else if (st && op == 2'h0 && n == hlen && rdy)
    begin
      if (sub == 2'h2 && unlocked)
      begin
        foreach (mem[i]) mem[i] = 8'hff;
        busy = BUSY_POLLS;
      end
      if (sub != 2'h2)
        unlocked = sub == 2'h3;
    end
endmodule : ee_word_model

// ===== verif/serial_eeprom_cmd_master_test.sv
// self-checking bench for the eeprom command master
`timescale 1ns/1ns
module serial_eeprom_cmd_master_test;
  logic clk_i, sys_rst_i, cmd_valid_i, cmd_ready_o, done_o;
  logic chip_select_o, shift_clock_o, eeprom_serial_input_o, eeprom_serial_output_i, word_width_select_i;
  logic [2:0] cmd_i;
  logic [6:0] cmd_addr_i;
  logic [15:0] cmd_wdata_i, rdata_o;
  int n_mismatch = 0;
  int checked = 0;
  // half period of 4 gives the 80 ns shift clock
  serial_eeprom_cmd_master #(.HALF_CYC(4)) DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .word_width_select_i(word_width_select_i), .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .cmd_i(cmd_i),
    .cmd_addr_i(cmd_addr_i), .cmd_wdata_i(cmd_wdata_i), .done_o(done_o), .rdata_o(rdata_o),
    .chip_select_o(chip_select_o), .shift_clock_o(shift_clock_o),
    .eeprom_serial_input_o(eeprom_serial_input_o), .eeprom_serial_output_i(eeprom_serial_output_i));
  ee_word_model mem_u (.select_i(chip_select_o), .sclk_i(shift_clock_o), .din_i(eeprom_serial_input_o),
    .org_i(word_width_select_i), .dout_o(eeprom_serial_output_i));
  task automatic final_report;
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  task automatic run(input logic [2:0] c, input logic [6:0] a, input logic [15:0] d);
    int k;
    @(negedge clk_i);
    cmd_i = c;
    cmd_addr_i = a;
    cmd_wdata_i = d;
    cmd_valid_i = 1'b1;
    @(negedge clk_i);
    cmd_valid_i = 1'b0;
    for (k = 0; k < 4000 && done_o !== 1'b1; k++)
      @(negedge clk_i);
    if (k == 4000)
    begin
      n_mismatch++;
      $display("unexpected done_o expected 1 seen %b", done_o);
      final_report();
    end
  endtask : run
  task automatic chk(input logic [15:0] exp);
    checked++;
    if (rdata_o !== exp)
    begin
      n_mismatch++;
      $display("unexpected rdata_o expected %h seen %h", exp, rdata_o);
    end
  endtask : chk
  task automatic write_read_ends;
    run(ee_cmd_pkg::CMD_UNLOCK, 7'h00, 16'h0000);
    run(ee_cmd_pkg::CMD_WRITE, 7'h00, 16'ha5c3);
    run(ee_cmd_pkg::CMD_WRITE, 7'h3f, 16'h5a3c);
    run(ee_cmd_pkg::CMD_READ, 7'h3f, 16'h0000);
    chk(16'h5a3c);
    run(ee_cmd_pkg::CMD_READ, 7'h00, 16'h0000);
    chk(16'ha5c3);
  endtask : write_read_ends
  task automatic wipe_all;
    run(ee_cmd_pkg::CMD_BULK_WIPE, 7'h00, 16'h0000);
    run(ee_cmd_pkg::CMD_READ, 7'h15, 16'h0000);
    chk(16'hffff);
  endtask : wipe_all
  task automatic lock_blocks;
    run(ee_cmd_pkg::CMD_LOCK, 7'h00, 16'h0000);
    run(ee_cmd_pkg::CMD_WRITE, 7'h3f, 16'h1234);
    run(ee_cmd_pkg::CMD_READ, 7'h3f, 16'h0000);
    chk(16'hffff);
  endtask : lock_blocks
  // byte organisation: 7-bit addresses, 8-bit data zero-extended on the read side
  task automatic narrow_bytes;
    word_width_select_i = 1'b0;
    run(ee_cmd_pkg::CMD_READ, 7'h00, 16'h0000);
    chk(16'h00ff);
    run(ee_cmd_pkg::CMD_UNLOCK, 7'h00, 16'h0000);
    run(ee_cmd_pkg::CMD_WRITE, 7'h7f, 16'hff5a);
    run(ee_cmd_pkg::CMD_READ, 7'h7f, 16'h0000);
    chk(16'h005a);
    word_width_select_i = 1'b1;
  endtask : narrow_bytes
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial
  begin
    sys_rst_i = 1'b1;
    cmd_valid_i = 1'b0;
    cmd_i = 3'h0;
    cmd_addr_i = 7'h00;
    cmd_wdata_i = 16'h0000;
    word_width_select_i = 1'b1;
    repeat (12) @(negedge clk_i);
    sys_rst_i = 1'b0;
    write_read_ends();
    wipe_all();
    lock_blocks();
    narrow_bytes();
    final_report();
  end
endmodule : serial_eeprom_cmd_master_test
bind serial_eeprom_cmd_master serial_eeprom_cmd_master_asserts chk_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .cmd_i(cmd_i), .chip_select_o(chip_select_o),
  .shift_clock_o(shift_clock_o), .eeprom_serial_input_o(eeprom_serial_input_o));
